// file: design/dsl_tx.sv
// device end: registers over ahb-lite, word packing, lane mapping, coding
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ns
`include "dsl_params.svh"
module dsl_tx
    import dsl_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [14:0] i_value,
    input wire logic [14:0] q_value,
    input wire logic over_range_flag_a,
    input wire logic over_range_flag_b,
    output logic [3:0] preemph_level,
    output logic [2:0] dec_factor_out,
    output logic gain_boost,
    dsl_link_if.tx link
);
    logic [7:0] preemph_reg, preemph_next;
    logic [7:0] gain_reg, gain_next;
    logic [7:0] scrmf_reg, scrmf_next;
    logic [7:0] ctrl_reg, ctrl_next;  // 0 enable, 3:1 dec, 4 ddr, 5 pll
    logic [3:0] mode_reg, mode_next;
    logic [11:0] wa_reg, wa_next;
    logic we_reg, we_next;
    logic [31:0] rd_reg, rd_next;
    logic [31:0] word_reg, word_next;
    logic [2:0] dec_reg, dec_next;
    logic ddr_reg, ddr_next, pll_reg, pll_next, scron_reg, scron_next;
    logic [4:0] fpmf_reg, fpmf_next;
    logic [22:0] prbs_reg, prbs_next;
    logic [14:0] scram_reg, scram_next;
    logic [7:0] ramp_reg, ramp_next;
    logic [4:0] oct_reg, oct_next;
    logic [79:0] sym_reg, sym_next;
    logic rd_phase, en;
    dsl_link_s p;

    assign en = ctrl_reg[0];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rd_reg;
    assign preemph_level = preemph_reg[3:0];  // [RULE16]
    assign gain_boost = gain_reg[`DSL_BIT_BOOST];  // [RULE3]
    assign dec_factor_out = dec_reg;  // [RULE2]
    assign rd_phase = hsel && hready && htrans[1] && !hwrite;

    // fixed lookup by decimation, double rate and pll [RULE22]
    always_comb begin
        p = '0;
        p.legal = 1'b1;
        case ({dec_reg, ddr_reg, pll_reg})
            5'b000_1_0: p = '{4'd8, 6'd8, 4'd8, 3'd5, 4'd2, 3'd2, 1'b1};
            5'b001_1_0: p = '{4'd5, 6'd4, 4'd2, 3'd5, 4'd4, 3'd2, 1'b1};
            5'b001_1_1: p = '{4'd4, 6'd2, 4'd2, 3'd2, 4'd2, 3'd3, 1'b1};
            5'b010_0_0: p = '{4'd5, 6'd4, 4'd2, 3'd5, 4'd2, 3'd0, 1'b1};
            5'b010_0_1: p = '{4'd4, 6'd2, 4'd2, 3'd2, 4'd1, 3'd1, 1'b1};
            5'b010_1_0: p = '{4'd3, 6'd8, 4'd2, 3'd5, 4'd2, 3'd2, 1'b1};
            5'b010_1_1: p = '{4'd2, 6'd2, 4'd2, 3'd1, 4'd2, 3'd3, 1'b1};
            5'b011_0_0: p = '{4'd4, 6'd2, 4'd2, 3'd2, 4'd4, 3'd0, 1'b1};
            5'b011_1_0: p = '{4'd2, 6'd2, 4'd2, 3'd1, 4'd8, 3'd2, 1'b1};
            5'b100_0_0: p = '{4'd3, 6'd8, 4'd2, 3'd5, 4'd1, 3'd0, 1'b1};
            5'b100_0_1: p = '{4'd2, 6'd2, 4'd2, 3'd1, 4'd1, 3'd1, 1'b1};
            5'b100_1_0: p = '{4'd2, 6'd16, 4'd2, 3'd5, 4'd1, 3'd2, 1'b1};
            5'b100_1_1: p = '{4'd1, 6'd4, 4'd2, 3'd1, 4'd1, 3'd3, 1'b1};
            5'b101_0_0: p = '{4'd2, 6'd2, 4'd2, 3'd1, 4'd4, 3'd0, 1'b1};
            5'b101_1_0: p = '{4'd1, 6'd4, 4'd2, 3'd1, 4'd4, 3'd2, 1'b1};
            5'b110_0_0: p = '{4'd2, 6'd16, 4'd2, 3'd5, 4'd1, 3'd0, 1'b1};
            5'b110_0_1: p = '{4'd1, 6'd4, 4'd2, 3'd1, 4'd1, 3'd1, 1'b1};
            5'b110_1_0: p = '{4'd1, 6'd32, 4'd2, 3'd5, 4'd1, 3'd2, 1'b1};
            default: p.legal = 1'b0;
        endcase
    end

    // bus slave: zero wait, writes land after the data phase
    always_comb begin
        preemph_next = preemph_reg;
        gain_next = gain_reg;
        scrmf_next = scrmf_reg;
        ctrl_next = ctrl_reg;
        mode_next = mode_reg;
        we_next = hsel && hready && htrans[1] && hwrite;
        wa_next = hready ? haddr[11:0] : wa_reg;
        rd_next = rd_reg;
        if (we_reg) begin
            case (wa_reg)
                `DSL_OFS_PREEMPH: preemph_next = hwdata[7:0];
                `DSL_OFS_GAIN: gain_next = hwdata[7:0];
                `DSL_OFS_SCRMF: scrmf_next = hwdata[7:0];
                `DSL_OFS_CTRL: begin
                    ctrl_next = hwdata[7:0];
                    mode_next = hwdata[11:8];
                end
                default: ;
            endcase
        end
        if (rd_phase) begin
            case (haddr[11:0])
                `DSL_OFS_PREEMPH: rd_next = {24'h0, preemph_reg};
                `DSL_OFS_GAIN: rd_next = {24'h0, gain_reg};
                `DSL_OFS_SCRMF: rd_next = {24'h0, scrmf_reg};
                `DSL_OFS_CTRL: rd_next = {20'h0, mode_reg, ctrl_reg};
                `DSL_OFS_STATUS: rd_next = {2'h0, fpmf_reg, p.legal,
                    4'h0, p.kstep, 1'b0, p.rate, p.lanes, 2'b0, p.octets};
                `DSL_OFS_SAMPLE: rd_next = word_reg;
                default: rd_next = 32'h0;
            endcase
        end
    end

    // settings follow the registers only while the link is off [RULE23]
    always_comb begin
        dec_next = en ? dec_reg : ctrl_reg[3:1];
        ddr_next = en ? ddr_reg : ctrl_reg[4];
        pll_next = en ? pll_reg : ctrl_reg[5];
        // scrambler stays off until software sets it [RULE7]
        scron_next = en ? scron_reg : scrmf_reg[`DSL_BIT_SCRAMBLE];
        fpmf_next = en ? fpmf_reg : scrmf_reg[`DSL_FPMF_HI:`DSL_FPMF_LO];
        // i in the high half, q low; flags in bit 0 [RULE1]
        word_next = {i_value, over_range_flag_a, q_value, over_range_flag_b};
    end

    // lane symbols: prbs is raw, diff modes are constant, other data gets a simplified 8b/10b
    always_comb begin
        logic [7:0] oct;
        logic [7:0] pat;
        logic k;
        oct = 8'h0;
        pat = 8'h0;
        k = 1'b0;
        prbs_next = prbs_reg;
        scram_next = scram_reg;
        ramp_next = ramp_reg + 8'h01;
        oct_next = (oct_reg == p.octets[4:0] - 5'd1) ? 5'd0 : oct_reg + 5'd1;
        sym_next = '0;
        case (mode_reg)
            DSL_PRBS7: prbs_next = {prbs_reg[21:0], prbs_reg[6] ^ prbs_reg[5]};
            DSL_PRBS15: prbs_next = {prbs_reg[21:0],
                prbs_reg[14] ^ prbs_reg[13]};
            DSL_PRBS23: prbs_next = {prbs_reg[21:0],
                prbs_reg[22] ^ prbs_reg[17]};
            default: ;
        endcase
        // a two-octet sample word; tail bits stay zero [RULE21] [RULE18]
        pat = oct_reg[0] ? word_reg[23:16] : word_reg[31:24];
        case (mode_reg)
            DSL_NORMAL, DSL_TRANSPORT: oct = pat;  // [RULE14]
            DSL_RAMP: oct = ramp_reg;
            DSL_D215: oct = 8'hb5;
            DSL_K285, DSL_ILA: begin
                oct = 8'hbc;
                k = 1'b1;
            end
            DSL_RPAT: oct = ramp_reg ^ 8'h5a;
            default: oct = 8'h0;
        endcase
        if (scron_reg && !k) begin
            oct = oct ^ scram_reg[7:0];
            scram_next = {scram_reg[6:0], scram_reg[14:7] ^ oct};
        end
        // whole samples per lane, no control words [RULE19] [RULE20]
        for (int n = 0; n < `DSL_LANES; n++) begin
            if (4'(n) < p.lanes) begin  // [RULE17]
                case (mode_reg)
                    DSL_PRBS7, DSL_PRBS15, DSL_PRBS23:
                        sym_next[n*10 +: 10] = prbs_reg[9:0];  // [RULE15]
                    DSL_DIFF0: sym_next[n*10 +: 10] = 10'h000;
                    DSL_DIFF1: sym_next[n*10 +: 10] = 10'h3ff;
                    default: sym_next[n*10 +: 10] =  // [RULE5]
                        {k ^ ~oct[7], oct[7:5], k, oct[4:0]};
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            preemph_reg <= {4'h0, `DSL_PREEMPH_RST};
            gain_reg <= 8'h0;
            scrmf_reg <= 8'h0;
            ctrl_reg <= 8'h0;
            mode_reg <= 4'h0;
            wa_reg <= 12'h0;
            we_reg <= 1'b0;
            rd_reg <= 32'h0;
            word_reg <= 32'h0;
            dec_reg <= 3'h0;
            ddr_reg <= 1'b0;
            pll_reg <= 1'b0;
            scron_reg <= 1'b0;
            fpmf_reg <= 5'h0;
        end else begin
            preemph_reg <= preemph_next;
            gain_reg <= gain_next;
            scrmf_reg <= scrmf_next;
            ctrl_reg <= ctrl_next;
            mode_reg <= mode_next;
            wa_reg <= wa_next;
            we_reg <= we_next;
            rd_reg <= rd_next;
            word_reg <= word_next;
            dec_reg <= dec_next;
            ddr_reg <= ddr_next;
            pll_reg <= pll_next;
            scron_reg <= scron_next;
            fpmf_reg <= fpmf_next;
        end
    end

    // link state held in reset while disabled [RULE13]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prbs_reg <= 23'h7fffff;
            scram_reg <= 15'h7fff;
            ramp_reg <= 8'h0;
            oct_reg <= 5'h0;
            sym_reg <= '0;
        end else if (!en || !p.legal) begin
            prbs_reg <= 23'h7fffff;
            scram_reg <= 15'h7fff;
            ramp_reg <= 8'h0;
            oct_reg <= 5'h0;
            sym_reg <= '0;
        end else begin
            prbs_reg <= prbs_next;
            scram_reg <= scram_next;
            ramp_reg <= ramp_next;
            oct_reg <= oct_next;
            sym_reg <= sym_next;
        end
    end

    assign link.sym = sym_reg;
    // lanes powered only while enabled [RULE13] [RULE17]
    assign link.lane_on = (en && p.legal) ? 8'((9'h1 << p.lanes) - 9'h1)
                                          : 8'h0;
    assign link.raw = {8{mode_reg == DSL_PRBS7 || mode_reg == DSL_PRBS15 ||
        mode_reg == DSL_PRBS23}};
    assign link.rate = p.rate;  // [RULE6] [RULE10] [RULE11]
    assign link.scramble_on = scron_reg;
    assign link.link_up = en && p.legal;
endmodule : dsl_tx

// file: design/dsl_params.svh
// constants for the down-converter output serial link, both ends
// What this block does
// RULE1 - 16-bit word: 15-bit value, flag in bit0
// RULE2 - decimation bypass, 4, 8, 10, 16, 20, 32
// RULE3 - bit 4 of 0x200 adds 6.02 dB gain
// RULE4 - boost advised when oscillator tuned near zero
// RULE5 - up to eight lanes, 8b10b coded, serialized; code uses a simplified 10-bit mapping, lanes left parallel
// RULE6 - bit rate is clock times 1, 1.25, 2, 2.5
// RULE7 - scrambler off at reset, bit 7 of 0x201
// RULE8 - software writes frames per multiframe minus one
// RULE9 - multiframe length multiple of derived step
// RULE10 - double rate: 1 twice, 0 single rate
// RULE11 - five-fourths pll raises rate by 1.25
// RULE12 - clear link enable before changing parameters
// RULE13 - link held in reset while enable low
// RULE14 - normal, prbs, ramp, transport, fixed, constant modes
// RULE15 - prbs patterns bypass the 8b10b encoder
// RULE16 - pre-emphasis in 0x040 bits 3:0, reset 4
// RULE17 - lanes disabled from the highest downward
// RULE18 - sample width with control bits multiple of 4
// RULE19 - high density only when samples split lanes
// RULE20 - high density and control words always zero
// RULE21 - tail bits driven to zero
// RULE22 - derived parameters from fixed mode lookup
// RULE23 - link settings sampled only while enable low
`ifndef DSL_PARAMS_SVH
`define DSL_PARAMS_SVH
`define DSL_OFS_PREEMPH 12'h040
`define DSL_OFS_GAIN 12'h200
`define DSL_OFS_SCRMF 12'h201
`define DSL_OFS_CTRL 12'h300
`define DSL_OFS_STATUS 12'h304
`define DSL_OFS_SAMPLE 12'h308
`define DSL_BIT_BOOST 4
`define DSL_BIT_SCRAMBLE 7
`define DSL_FPMF_HI 6
`define DSL_FPMF_LO 2
`define DSL_PREEMPH_RST 4'h4
`define DSL_NPRIME 5'h10
`define DSL_LANES 8
`endif

// file: design/dsl_pkg.sv
// types for the down-converter output serial link
package dsl_pkg;
    typedef enum logic [2:0] {
        DSL_D1 = 3'h0, DSL_D4 = 3'h1, DSL_D8 = 3'h2, DSL_D10 = 3'h3,
        DSL_D16 = 3'h4, DSL_D20 = 3'h5, DSL_D32 = 3'h6
    } dsl_dec_e;
    typedef enum logic [3:0] {
        DSL_NORMAL = 4'h0, DSL_PRBS7 = 4'h1, DSL_PRBS15 = 4'h2,
        DSL_PRBS23 = 4'h3, DSL_RAMP = 4'h4, DSL_TRANSPORT = 4'h5,
        DSL_D215 = 4'h6, DSL_K285 = 4'h7, DSL_ILA = 4'h8,
        DSL_RPAT = 4'h9, DSL_DIFF0 = 4'ha, DSL_DIFF1 = 4'hb
    } dsl_mode_e;
    typedef struct packed {
        logic [3:0] lanes;
        logic [5:0] octets;
        logic [3:0] conv;
        logic [2:0] spf;
        logic [3:0] kstep;
        logic [2:0] rate;  // 0:1x 1:1.25x 2:2x 3:2.5x
        logic legal;
    } dsl_link_s;
endpackage : dsl_pkg

// file: design/dsl_link_if.sv
// lane bundle between the link transmitter and the receiver end
`timescale 1ns/1ns
interface dsl_link_if;
    logic [79:0] sym;       // eight 10-bit lane symbols
    logic [7:0] lane_on;
    logic [7:0] raw;        // lane carries unencoded pattern bits
    logic [2:0] rate;
    logic scramble_on;
    logic link_up;
    modport tx (output sym, output lane_on, output raw, output rate,
        output scramble_on, output link_up);
    modport rx (input sym, input lane_on, input raw, input rate,
        input scramble_on, input link_up);
endinterface : dsl_link_if

// file: design/dsl_rx.sv
// receiver end: counts frames, recovers octets from lane 0
`timescale 1ns/1ns
`include "dsl_params.svh"
module dsl_rx
    import dsl_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [4:0] frames_per_multiframe_minus_one,
    dsl_link_if.rx link,
    output logic [7:0] rx_octet,
    output logic rx_octet_valid,
    output logic [7:0] rx_lanes_seen,
    output logic rx_raw,
    output logic [4:0] rx_frame_count
);
    logic [7:0] oct_reg, oct_next;
    logic val_reg, val_next;
    logic [4:0] fc_reg, fc_next;
    logic [15:0] dscr_reg, dscr_next;
    logic up_reg, up_next;
    logic live;

    // lane 0 still shows the reset symbol in the first cycle of link up,
    // so decoding waits one cycle to stay in step with the scrambler
    assign live = link.link_up && up_reg;

    always_comb begin
        logic [7:0] d;
        d = {link.sym[8:6], link.sym[4:0]};
        dscr_next = dscr_reg;
        oct_next = oct_reg;
        up_next = link.link_up;
        val_next = live && !link.raw[0];
        // multiframe counter wraps at the programmed length [RULE8] [RULE9]
        fc_next = !link.link_up ? 5'h0 :
            (fc_reg == frames_per_multiframe_minus_one) ? 5'h0 :
            fc_reg + 5'h01;
        if (live && !link.raw[0]) begin
            if (link.scramble_on && !link.sym[5]) begin
                oct_next = d ^ dscr_reg[7:0];
                dscr_next = {1'b0, dscr_reg[6:0], dscr_reg[14:7] ^ d};
            end else begin
                oct_next = d;
            end
        end
        if (!live) begin
            dscr_next = 16'h7fff;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oct_reg <= 8'h0;
            val_reg <= 1'b0;
            fc_reg <= 5'h0;
            dscr_reg <= 16'h7fff;
            up_reg <= 1'b0;
        end else begin
            oct_reg <= oct_next;
            val_reg <= val_next;
            fc_reg <= fc_next;
            dscr_reg <= dscr_next;
            up_reg <= up_next;
        end
    end

    assign rx_octet = oct_reg;
    assign rx_octet_valid = val_reg;
    assign rx_lanes_seen = link.lane_on;
    assign rx_raw = link.raw[0];
    assign rx_frame_count = fc_reg;
endmodule : dsl_rx

// file: dv/dsl_checker.sv
// assertions on the lane bundle between the two link ends
`timescale 1ns/1ns
module dsl_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [79:0] sym,
    input wire logic [7:0] lane_on,
    input wire logic [7:0] raw,
    input wire logic [2:0] rate,
    input wire logic scramble_on,
    input wire logic link_up
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // a gap in the mask would strand the receiver lane map
    lanes_from_zero_a: assert property (
        ((lane_on + 8'h1) & lane_on) == 8'h0)
        else $error("active lanes not contiguous from lane 0");
    lanes_off_down_a: assert property (
        !link_up |-> lane_on == 8'h0)
        else $error("lanes active while link held off");
    lane_zero_up_a: assert property (link_up |-> lane_on[0])
        else $error("link up without lane 0");
    rate_code_a: assert property (rate <= 3'h3)
        else $error("line rate code out of range");
    rate_held_a: assert property (
        link_up && $past(link_up) |-> $stable(rate))
        else $error("line rate changed while link up");
    scramble_held_a: assert property (
        link_up && $past(link_up) |-> $stable(scramble_on))
        else $error("scrambler changed while link up");
    lanes_held_a: assert property (
        link_up && $past(link_up) |-> $stable(lane_on))
        else $error("lane mask changed while link up");
    raw_uniform_a: assert property (
        raw == 8'h0 || raw == 8'hff)
        else $error("coding bypass not uniform across lanes");

    cover property ($rose(link_up));
    cover property (link_up && raw == 8'hff);
    cover property (link_up && rate == 3'h3);
    cover property (link_up && sym != 80'h0);
endmodule : dsl_checker

// file: dv/ddc_output_serial_link_tx_tb.sv
// self-checking bench: both link ends joined, driven over ahb-lite
`timescale 1ns/1ns
`include "dsl_params.svh"
module ddc_output_serial_link_tx_tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, dec_factor_out;
    logic [14:0] i_value, q_value;
    logic over_range_flag_a, over_range_flag_b, gain_boost;
    logic [3:0] preemph_level;
    logic [4:0] fpmf, rx_frame_count;
    logic [7:0] rx_octet, rx_lanes_seen;
    logic rx_octet_valid, rx_raw;
    int bad_count, checks, seed, v, kf;
    // one row per legal decimation / rate combination
    int tdec [18] = '{0,1,1,2,2,2,2,3,3,4,4,4,4,5,5,6,6,6};
    int tddr [18] = '{1,1,1,0,0,1,1,0,1,0,0,1,1,0,1,0,0,1};
    int tp [18] = '{0,0,1,0,1,0,1,0,0,0,1,0,1,0,0,0,1,0};
    int tl [18] = '{8,5,4,5,4,3,2,4,2,3,2,2,1,2,1,2,1,1};
    int tf [18] = '{8,4,2,4,2,8,2,2,2,8,2,16,4,2,4,16,4,32};
    int tks [18] = '{2,4,2,2,1,2,2,4,8,1,1,1,1,4,4,1,1,1};

    dsl_link_if u_dsl_link_if ();
    dsl_tx u_dsl_tx (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .i_value, .q_value, .over_range_flag_a, .over_range_flag_b,
        .preemph_level, .dec_factor_out, .gain_boost, .link(u_dsl_link_if));
    dsl_rx u_dsl_rx (.hclk, .hresetn, .frames_per_multiframe_minus_one(fpmf),
        .link(u_dsl_link_if), .rx_octet, .rx_octet_valid, .rx_lanes_seen,
        .rx_raw, .rx_frame_count);
    dsl_checker u_dsl_checker (.hclk, .hresetn, .sym(u_dsl_link_if.sym),
        .lane_on(u_dsl_link_if.lane_on), .raw(u_dsl_link_if.raw),
        .rate(u_dsl_link_if.rate), .scramble_on(u_dsl_link_if.scramble_on),
        .link_up(u_dsl_link_if.link_up));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task automatic results;
        if (bad_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one single-word transfer; every wait bounded
    task automatic bus(input logic [11:0] a, input logic w,
        input logic [31:0] d, output logic [31:0] r);
        int n;
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        r = hrdata;
        if (n >= 50) begin
            bad_count++;
            results();
        end
    endtask : bus

    // settings land with the link off, then the link is switched on
    task automatic setup(input int dc, input int dd, input int p5,
        input logic [3:0] md);
        logic [31:0] w;
        w = {20'h0, md, 2'b00, 1'(p5), 1'(dd), 3'(dc), 1'b0};
        bus(`DSL_OFS_CTRL, 1'b1, w, rd);
        bus(`DSL_OFS_CTRL, 1'b1, w | 32'h1, rd);
        repeat (4) @(posedge hclk);
    endtask : setup

    function automatic logic [31:0] exp_status(input int k);
        logic [31:0] s;
        s = 32'h0100_0000;
        s[5:0] = 6'(tf[k]);
        s[11:8] = 4'(tl[k]);
        s[14:12] = 3'(2 * tddr[k] + tp[k]);
        s[19:16] = 4'(tks[k]);
        s[29:25] = 5'(kf - 1);
        return s;
    endfunction : exp_status

    // fixed characters as the receiver should recover them
    function automatic logic [31:0] exp_octet(input int m);
        case (m)
            6: return 32'hb5;
            7, 8: return 32'hbc;
            11: return 32'hff;
            default: return 32'h0;
        endcase
    endfunction : exp_octet

    initial begin
        seed = 45;
        bad_count = 0;
        checks = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        i_value = 15'h0;
        q_value = 15'h0;
        over_range_flag_a = 1'b0;
        over_range_flag_b = 1'b0;
        fpmf = 5'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("preemph out", 32'h4, {28'h0, preemph_level});
        chk("scramble", 32'h0, {31'h0, u_dsl_link_if.scramble_on});
        bus(`DSL_OFS_PREEMPH, 1'b0, 32'h0, rd);
        chk("preemph reg", {28'h0, `DSL_PREEMPH_RST}, rd & 32'hf);
        bus(12'h100, 1'b0, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        for (int k = 0; k < 4; k++) begin
            v = (k == 0) ? 15 : $random(seed) & 15;
            bus(`DSL_OFS_PREEMPH, 1'b1, 32'(v), rd);
            bus(`DSL_OFS_PREEMPH, 1'b0, 32'h0, rd);
            chk("preemph reg", 32'(v), rd & 32'hf);
            chk("preemph out", 32'(v), {28'h0, preemph_level});
        end
        for (int b = 1; b >= 0; b--) begin
            bus(`DSL_OFS_GAIN, 1'b1, 32'(b) << `DSL_BIT_BOOST,
                rd);
            @(posedge hclk);
            chk("gain boost", 32'(b), {31'h0, gain_boost});
        end
        v = $random(seed) & 31;
        fpmf <= 5'(v);
        bus(`DSL_OFS_SCRMF, 1'b1, 32'h80 | (32'(v) << `DSL_FPMF_LO), rd);
        bus(`DSL_OFS_SCRMF, 1'b0, 32'h0, rd);
        chk("fpmf reg", 32'h80 | (32'(v) << 2), rd & 32'hff);
        setup(2, 0, 0, 4'h0);
        chk("scramble on", 32'h1, {31'h0, u_dsl_link_if.scramble_on});
        bus(`DSL_OFS_SCRMF, 1'b1, 32'h0, rd);
        repeat (3) @(posedge hclk);
        chk("scramble held", 32'h1, {31'h0, u_dsl_link_if.scramble_on});
        bus(`DSL_OFS_CTRL, 1'b1, 32'h4, rd);
        repeat (3) @(posedge hclk);
        chk("scramble off", 32'h0, {31'h0, u_dsl_link_if.scramble_on});
        for (int k = 0; k < 18; k++) begin
            i_value <= 15'($random(seed));
            q_value <= (k == 0) ? 15'h7fff : 15'($random(seed));
            over_range_flag_a <= k[0];
            over_range_flag_b <= ~k[0];
            kf = 32 - tks[k] * ($random(seed) & 1);
            fpmf <= 5'(kf - 1);
            bus(`DSL_OFS_SCRMF, 1'b1, 32'(kf - 1) << `DSL_FPMF_LO,
                rd);
            setup(tdec[k], tddr[k], tp[k], 4'h0);
            v = (1 << tl[k]) - 1;
            chk("link up", 32'h1, {31'h0, u_dsl_link_if.link_up});
            chk("lanes", 32'(v), {24'h0, u_dsl_link_if.lane_on});
            chk("lanes seen", 32'(v), {24'h0, rx_lanes_seen});
            chk("rate", 32'(2 * tddr[k] + tp[k]),
                {29'h0, u_dsl_link_if.rate});
            chk("decimation", 32'(tdec[k]), {29'h0, dec_factor_out});
            chk("coded", 32'h0, {24'h0, u_dsl_link_if.raw});
            bus(`DSL_OFS_STATUS, 1'b0, 32'h0, rd);
            chk("status", exp_status(k), rd & 32'h3f0f7f3f);
            bus(`DSL_OFS_SAMPLE, 1'b0, 32'h0, rd);
            chk("sample", {i_value, over_range_flag_a, q_value,
                over_range_flag_b}, rd);
            repeat (24) @(posedge hclk);
            @(negedge hclk);
            chk("frames", 32'(32 % kf), {27'h0, rx_frame_count});
            @(posedge hclk);
        end
        setup(0, 0, 0, 4'h0);
        chk("illegal down", 32'h0, {31'h0, u_dsl_link_if.link_up});
        chk("illegal lanes", 32'h0, {24'h0, u_dsl_link_if.lane_on});
        for (int m = 0; m < 12; m++) begin
            setup(1, 1, 0, 4'(m));
            v = (m >= 1 && m <= 3) ? 255 : 0;
            chk("mode up", 32'h1, {31'h0, u_dsl_link_if.link_up});
            chk("raw", 32'(v), {24'h0, u_dsl_link_if.raw});
            chk("rx raw", 32'(v & 1), {31'h0, rx_raw});
            chk("rx valid", 32'(v == 0), {31'h0, rx_octet_valid});
            if (m >= 6 && m != 9) begin
                chk("rx octet", exp_octet(m), {24'h0, rx_octet});
            end
        end
        bus(`DSL_OFS_SCRMF, 1'b1, 32'h80, rd);
        setup(1, 1, 0, 4'h6);
        chk("rx descrambled", 32'hb5, {24'h0, rx_octet});
        chk("hresp", 32'h0, {31'h0, hresp});
        results();
    end
endmodule : ddc_output_serial_link_tx_tb
